/* logic/link_status_pkg.sv */
// Shared constants for the per-port link status register block.
// Assumes an AXI4-Lite master with 32-bit data and a 9-bit byte address.
package link_status_pkg;

    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int          ADDR_W     = 9;
    localparam int          IDX_W      = 7;
    localparam int          NPORTS     = 5;
    localparam int          FLAG_W     = 5 * NPORTS;

    // ----------------------------------------------------------------
    // Register indexes (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [6:0]  IDX_PORT1  = 7'h19;
    localparam logic [6:0]  IDX_PORT2  = 7'h29;
    localparam logic [6:0]  IDX_PORT3  = 7'h39;
    localparam logic [6:0]  IDX_PORT4  = 7'h49;
    localparam logic [6:0]  IDX_PORT5  = 7'h59;
    localparam logic [6:0]  IDX_IRQ_ST = 7'h70;
    localparam logic [6:0]  IDX_IRQ_MK = 7'h71;

    // ----------------------------------------------------------------
    // Field positions of a port status byte
    // ----------------------------------------------------------------
    localparam int          BIT_XOVER  = 7;
    localparam int          BIT_RSV_HI = 6;
    localparam int          BIT_POL    = 5;
    localparam int          BIT_TXFC   = 4;
    localparam int          BIT_RXFC   = 3;
    localparam int          BIT_SPEED  = 2;
    localparam int          BIT_DUPLEX = 1;
    localparam int          BIT_RSV_LO = 0;

    // ----------------------------------------------------------------
    // Reset values and codes
    // ----------------------------------------------------------------
    localparam logic [4:0]  XOVER_RST  = 5'h1f;
    localparam logic [2:0]  PORT_NONE  = 3'h7;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : link_status_pkg

/* logic/flag_sync.sv */
// Two-flop synchroniser for the asynchronous link state flags.
// Assumes the flags change slowly compared with aclk.
`timescale 1ns/1ps
`default_nettype none
module flag_sync #(
    parameter int W = link_status_pkg::FLAG_W
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } sync_s;

    sync_s s_q;
    sync_s s_d;

    // Meta stage feeds only the stable stage
    always_comb begin
        s_d      = s_q;
        s_d.meta = async_in;
        s_d.stab = s_q.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.stab;
endmodule : flag_sync
`default_nettype wire

/* logic/irq_status.sv */
// Sticky event status with write-one-to-clear, a mask and a level irq.
// Assumes one-cycle write pulses from the bus slave on the same clock.
`timescale 1ns/1ps
`default_nettype none
module irq_status (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [4:0] event_set,
    input  wire logic       stat_we,
    input  wire logic       mask_we,
    input  wire logic [4:0] wr_data,
    output logic      [4:0] status,
    output logic      [4:0] mask,
    output logic            irq
);
    typedef struct packed {
        logic [4:0] stat;
        logic [4:0] mask;
    } irq_s;

    irq_s s_q;
    irq_s s_d;

    // Set wins over clear so an event in the clearing cycle survives
    always_comb begin
        s_d = s_q;
        if (stat_we) begin
            s_d.stat = s_q.stat & ~wr_data;
        end
        s_d.stat = s_d.stat | event_set;
        if (mask_we) begin
            s_d.mask = wr_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign status = s_q.stat;
    assign mask   = s_q.mask;
    assign irq    = |(s_q.stat & s_q.mask);
endmodule : irq_status
`default_nettype wire

/* logic/port_link_status_regs.sv */
// Per-port link status registers of a five-port switch, AXI4-Lite slave.
// Assumes link flags arrive asynchronously from the port PHYs and that
// aclk and aresetn come from the switch core.
// Functional notes
// - Bit 7: read/write crossover select, resets one
// - Polarity reversed flag, read-only, resets zero
// - Transmit flow control active flag, read-only
// - Receive flow control active flag, read-only
// - Speed flag: one faster, zero slower
// - Duplex flag: one full, zero half
// - Five identical copies at indexes 0x19..0x59
`timescale 1ns/1ps
`default_nettype none
module port_link_status_regs (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [8:0]  awaddr,
    // AXI4-Lite write data
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    // AXI4-Lite write response
    output logic             bvalid,
    input  wire logic        bready,
    output logic      [1:0]  bresp,
    // AXI4-Lite read address
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [8:0]  araddr,
    // AXI4-Lite read data
    output logic             rvalid,
    input  wire logic        rready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp,
    // Live link state per port, bit n is port n+1
    input  wire logic [4:0]  pol_reversed,
    input  wire logic [4:0]  tx_flow_active,
    input  wire logic [4:0]  rx_flow_active,
    input  wire logic [4:0]  speed_fast,
    input  wire logic [4:0]  full_duplex,
    // Crossover scheme per port, one = alternate scheme
    output logic      [4:0]  crossover_scheme_select,
    // Link change interrupt
    output logic             irq
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------

    // Register index to port number, PORT_NONE when not a port register
    function automatic logic [2:0] port_of(input logic [6:0] idx);
        logic [2:0] p;
        p = link_status_pkg::PORT_NONE;
        case (idx)
            link_status_pkg::IDX_PORT1: p = 3'h0;
            link_status_pkg::IDX_PORT2: p = 3'h1;
            link_status_pkg::IDX_PORT3: p = 3'h2;
            link_status_pkg::IDX_PORT4: p = 3'h3;
            link_status_pkg::IDX_PORT5: p = 3'h4;
            default:                    p = link_status_pkg::PORT_NONE;
        endcase
        return p;
    endfunction : port_of

    // Index taken from a byte address, low two bits ignored
    function automatic logic [6:0] idx_of(input logic [8:0] addr);
        return addr[8:2];
    endfunction : idx_of

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        aw_held;
        logic [8:0]  aw_addr;
        logic        w_held;
        logic [7:0]  w_byte;
        logic        w_lane0;
        logic        b_valid;
        logic [1:0]  b_resp;
        logic        r_valid;
        logic [31:0] r_data;
        logic [1:0]  r_resp;
        logic [4:0]  xover;
        logic [24:0] prev_flags;
    } regs_s;

    regs_s       s_q;
    regs_s       s_d;

    logic [24:0] flags_s;
    logic [4:0]  pol_s;
    logic [4:0]  txfc_s;
    logic [4:0]  rxfc_s;
    logic [4:0]  speed_s;
    logic [4:0]  duplex_s;
    logic [24:0] flag_diff;
    logic [4:0]  link_event;
    logic        wr_do;
    logic [6:0]  wr_idx;
    logic [2:0]  wr_port;
    logic        ar_fire;
    logic [6:0]  rd_idx;
    logic [2:0]  rd_port;
    logic        irq_stat_we;
    logic        irq_mask_we;
    logic [4:0]  irq_stat;
    logic [4:0]  irq_mask;

    // ----------------------------------------------------------------
    // Link flag synchronisation and change events
    // ----------------------------------------------------------------

    // Flags come from the PHY side, so they are synchronised first
    flag_sync #(
        .W        (link_status_pkg::FLAG_W)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({pol_reversed, tx_flow_active, rx_flow_active,
                    speed_fast, full_duplex}),
        .sync_out (flags_s)
    );

    // Field split of the synchronised vector
    assign pol_s    = flags_s[24:20];
    assign txfc_s   = flags_s[19:15];
    assign rxfc_s   = flags_s[14:10];
    assign speed_s  = flags_s[9:5];
    assign duplex_s = flags_s[4:0];

    // Any flag of a port that moved raises that port's event
    assign flag_diff  = flags_s ^ s_q.prev_flags;
    assign link_event = flag_diff[24:20] | flag_diff[19:15] | flag_diff[14:10]
                      | flag_diff[9:5] | flag_diff[4:0];

    // Status byte of one port; reserved bits read as zero
    function automatic logic [7:0] status_byte(input logic [2:0] p,
                                               input logic [4:0] xo);
        logic [7:0] b;
        b = 8'h00;
        b[link_status_pkg::BIT_XOVER]  = xo[p];
        b[link_status_pkg::BIT_POL]    = pol_s[p];
        b[link_status_pkg::BIT_TXFC]   = txfc_s[p];
        b[link_status_pkg::BIT_RXFC]   = rxfc_s[p];
        b[link_status_pkg::BIT_SPEED]  = speed_s[p];
        b[link_status_pkg::BIT_DUPLEX] = duplex_s[p];
        return b;
    endfunction : status_byte

    // ----------------------------------------------------------------
    // AXI4-Lite handshakes
    // ----------------------------------------------------------------

    // One write and one read at a time keeps the slave simple
    assign awready = !s_q.aw_held;
    assign wready  = !s_q.w_held;
    assign arready = !s_q.r_valid;
    assign ar_fire = arvalid && arready;
    assign wr_do   = s_q.aw_held && s_q.w_held && !s_q.b_valid;
    assign wr_idx  = idx_of(s_q.aw_addr);
    assign wr_port = port_of(wr_idx);
    assign rd_idx  = idx_of(araddr);
    assign rd_port = port_of(rd_idx);

    // Interrupt register writes need byte lane 0
    assign irq_stat_we = wr_do && s_q.w_lane0
                       && (wr_idx == link_status_pkg::IDX_IRQ_ST);
    assign irq_mask_we = wr_do && s_q.w_lane0
                       && (wr_idx == link_status_pkg::IDX_IRQ_MK);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d            = s_q;
        s_d.prev_flags = flags_s;

        // Address and data are taken in either order
        if (awvalid && awready) begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            s_d.w_held  = 1'b1;
            s_d.w_byte  = wdata[7:0];
            s_d.w_lane0 = wstrb[0];
        end

        // Write commit; read-only and reserved bits are never stored
        if (wr_do) begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.b_valid = 1'b1;
            s_d.b_resp  = link_status_pkg::RESP_SLVERR;
            if (wr_port != link_status_pkg::PORT_NONE) begin
                s_d.b_resp = link_status_pkg::RESP_OKAY;
                if (s_q.w_lane0) begin
                    s_d.xover[wr_port] = s_q.w_byte[link_status_pkg::BIT_XOVER];
                end
            end else if (wr_idx == link_status_pkg::IDX_IRQ_ST
                         || wr_idx == link_status_pkg::IDX_IRQ_MK) begin
                s_d.b_resp = link_status_pkg::RESP_OKAY;
            end
        end else if (s_q.b_valid && bready) begin
            s_d.b_valid = 1'b0;
        end

        // Reads sample live flags and change nothing else
        if (ar_fire) begin
            s_d.r_valid = 1'b1;
            s_d.r_data  = 32'h0000_0000;
            s_d.r_resp  = link_status_pkg::RESP_OKAY;
            if (rd_port != link_status_pkg::PORT_NONE) begin
                s_d.r_data[7:0] = status_byte(rd_port, s_q.xover);
            end else if (rd_idx == link_status_pkg::IDX_IRQ_ST) begin
                s_d.r_data[4:0] = irq_stat;
            end else if (rd_idx == link_status_pkg::IDX_IRQ_MK) begin
                s_d.r_data[4:0] = irq_mask;
            end else begin
                s_d.r_resp = link_status_pkg::RESP_SLVERR;
            end
        end else if (s_q.r_valid && rready) begin
            s_d.r_valid = 1'b0;
        end
    end

    // Crossover selects come up in the alternate scheme
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q       <= '0;
            s_q.xover <= link_status_pkg::XOVER_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt
    // ----------------------------------------------------------------
    irq_status u_irq (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .event_set (link_event),
        .stat_we   (irq_stat_we),
        .mask_we   (irq_mask_we),
        .wr_data   (s_q.w_byte[4:0]),
        .status    (irq_stat),
        .mask      (irq_mask),
        .irq       (irq)
    );

    // Outputs straight from flip-flops
    assign bvalid                  = s_q.b_valid;
    assign bresp                   = s_q.b_resp;
    assign rvalid                  = s_q.r_valid;
    assign rdata                   = s_q.r_data;
    assign rresp                   = s_q.r_resp;
    assign crossover_scheme_select = s_q.xover;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_xover_write: assert property (
        wr_do && s_q.w_lane0 && wr_port != link_status_pkg::PORT_NONE
        |=> crossover_scheme_select[$past(wr_port)]
            == $past(s_q.w_byte[link_status_pkg::BIT_XOVER]))
        else $error("crossover select not written");

    chk_pol_read: assert property (
        ar_fire && rd_port != link_status_pkg::PORT_NONE
        |=> rdata[link_status_pkg::BIT_POL] == $past(pol_s[rd_port]))
        else $error("polarity flag wrong");

    chk_txfc_read: assert property (
        ar_fire && rd_port != link_status_pkg::PORT_NONE
        |=> rdata[link_status_pkg::BIT_TXFC] == $past(txfc_s[rd_port]))
        else $error("tx flow flag wrong");

    chk_rxfc_read: assert property (
        ar_fire && rd_port != link_status_pkg::PORT_NONE
        |=> rdata[link_status_pkg::BIT_RXFC] == $past(rxfc_s[rd_port]))
        else $error("rx flow flag wrong");

    chk_speed_read: assert property (
        ar_fire && rd_port != link_status_pkg::PORT_NONE
        |=> rdata[link_status_pkg::BIT_SPEED] == $past(speed_s[rd_port]))
        else $error("speed flag wrong");

    chk_duplex_read: assert property (
        ar_fire && rd_port != link_status_pkg::PORT_NONE
        |=> rdata[link_status_pkg::BIT_DUPLEX] == $past(duplex_s[rd_port]))
        else $error("duplex flag wrong");

    chk_unmapped_resp: assert property (
        ar_fire && rd_port == link_status_pkg::PORT_NONE
        && rd_idx != link_status_pkg::IDX_IRQ_ST
        && rd_idx != link_status_pkg::IDX_IRQ_MK
        |=> rvalid && rresp == link_status_pkg::RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read not refused");

    chk_read_no_effect: assert property (
        ar_fire && !wr_do |=> $stable(crossover_scheme_select))
        else $error("read changed crossover select");

    chk_resv_zero: assert property (
        ar_fire && rd_port != link_status_pkg::PORT_NONE
        |=> rdata[31:8] == 24'h0 && !rdata[link_status_pkg::BIT_RSV_HI]
            && !rdata[link_status_pkg::BIT_RSV_LO])
        else $error("reserved bits not zero");

    chk_write_answer: assert property (
        wr_do |=> bvalid)
        else $error("write commit gave no response");

    chk_read_answer: assert property (
        ar_fire |=> rvalid)
        else $error("read address gave no answer");

    chk_event_sticky: assert property (
        link_event != 5'h00 |=> (irq_stat & $past(link_event)) == $past(link_event))
        else $error("link change not recorded in status");

    chk_w1c_clear: assert property (
        irq_stat_we && link_event == 5'h00 |=> (irq_stat & $past(s_q.w_byte[4:0])) == 5'h00)
        else $error("status bits not cleared by write");

    cov_xover_clear: cover property (
        wr_do && wr_port == 3'h4 && !s_q.w_byte[link_status_pkg::BIT_XOVER]);
    cov_port_read: cover property (
        ar_fire && rd_port == 3'h2 ##1 rvalid [*2] ##1 !rvalid);
    cov_irq_raise: cover property (!irq ##1 irq);

endmodule : port_link_status_regs
`default_nettype wire

/* test/test_port_link_status_regs.sv */
// Self-checking bench for the per-port link status register block.
// Assumes the block alone on one 100 MHz clock, driven over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module test_port_link_status_regs;

    // ----------------------------------------------------------------
    // Signals and instance
    // ----------------------------------------------------------------
    logic        aclk, aresetn;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq;
    logic [8:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [4:0]  flags [5];
    logic [4:0]  crossover_scheme_select;
    logic [6:0]  idx_tab [5];
    logic [31:0] rd;
    logic [1:0]  rsp;
    int          err_count, compares;

    port_link_status_regs u_port_link_status_regs (
        .aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .pol_reversed(flags[0]), .tx_flow_active(flags[1]), .rx_flow_active(flags[2]),
        .speed_fast(flags[3]), .full_duplex(flags[4]),
        .crossover_scheme_select(crossover_scheme_select), .irq(irq)
    );

    // ----------------------------------------------------------------
    // Clock, time-zero values, watchdog
    // ----------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Bound is far above the under one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        results();
    end

    // ----------------------------------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Ready is sampled at the falling edge, where it equals its value at the next rising edge
    task automatic axi_write(input logic [8:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] resp);
        bit aw_hit, w_hit, aw_done, w_done, b_hit;
        int n;
        @(posedge aclk);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= s; bready <= 1'b1;
        aw_done = 0; w_done = 0; b_hit = 0; n = 0;
        while (!b_hit) begin
            @(negedge aclk);
            aw_hit = !aw_done && awready;
            w_hit  = !w_done && wready;
            b_hit  = aw_done && w_done && bvalid;
            resp   = bresp;
            @(posedge aclk);
            if (aw_hit) begin awvalid <= 1'b0; aw_done = 1; end
            if (w_hit) begin wvalid <= 1'b0; w_done = 1; end
            if (b_hit) bready <= 1'b0;
            n++;
        end
        // Both halves taken at once, answer one cycle after they are held
        check("write latency", n, 32'h3);
    endtask : axi_write

    task automatic axi_read(input logic [8:0] a, output logic [31:0] d, output logic [1:0] resp);
        bit ar_hit, ar_done, r_hit;
        int n;
        @(posedge aclk);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
        ar_done = 0; r_hit = 0; n = 0;
        while (!r_hit) begin
            @(negedge aclk);
            ar_hit = !ar_done && arready;
            r_hit  = ar_done && rvalid;
            d      = rdata;
            resp   = rresp;
            @(posedge aclk);
            if (ar_hit) begin arvalid <= 1'b0; ar_done = 1; end
            if (r_hit) rready <= 1'b0;
            n++;
        end
        // Read answer stands the cycle after the address is taken
        check("read latency", n, 32'h2);
    endtask : axi_read

    // Port p (0..4) byte address
    function automatic logic [8:0] port_addr(input int p);
        return {idx_tab[p], 2'b00};
    endfunction : port_addr

    task automatic results();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
        rready = 1'b0; awaddr = 9'h000; araddr = 9'h000; wdata = 32'h0; wstrb = 4'h0;
        for (int i = 0; i < 5; i++) flags[i] = 5'h00;
        idx_tab = '{link_status_pkg::IDX_PORT1, link_status_pkg::IDX_PORT2, link_status_pkg::IDX_PORT3,
                    link_status_pkg::IDX_PORT4, link_status_pkg::IDX_PORT5};
        err_count = 0;
        compares = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;

        // Reset values of all five copies
        check("xover reset", {27'h0, crossover_scheme_select}, 32'h1f);
        check("irq reset", {31'h0, irq}, 32'h0);
        for (int p = 0; p < 5; p++) begin
            axi_read(port_addr(p), rd, rsp);
            check("port reset", rd, 32'h80);
            check("port resp", {30'h0, rsp}, 32'h0);
        end
        $display("test reset values done");

        // Each flag of each port alone, read twice, then cleared
        for (int p = 0; p < 5; p++) begin
            for (int f = 0; f < 5; f++) begin
                @(posedge aclk);
                flags[f][p] <= 1'b1;
                repeat (5) @(posedge aclk);
                axi_read(port_addr(p), rd, rsp);
                check("flag set", rd, 32'h80 | (32'h20 >> f));
                axi_read(port_addr(p), rd, rsp);
                check("flag reread", rd, 32'h80 | (32'h20 >> f));
                axi_read(port_addr((p + 1) % 5), rd, rsp);
                check("other port", rd, 32'h80);
                @(posedge aclk);
                flags[f][p] <= 1'b0;
                repeat (5) @(posedge aclk);
                axi_read(port_addr(p), rd, rsp);
                check("flag clear", rd, 32'h80);
            end
        end
        $display("test flag fields done");

        // Crossover select written and read back, then a write without byte lane 0 leaves it alone
        axi_write(port_addr(2), 32'h0000_0000, 4'h1, rsp);
        check("xover wr resp", {30'h0, rsp}, 32'h0);
        check("xover out", {27'h0, crossover_scheme_select}, 32'h1b);
        axi_read(port_addr(2), rd, rsp);
        check("xover read", rd, 32'h00);
        axi_write(port_addr(2), 32'h0000_0080, 4'h0, rsp);
        check("no strobe", {27'h0, crossover_scheme_select}, 32'h1b);
        axi_write(port_addr(2), 32'h0000_0080, 4'h1, rsp);
        check("xover back", {27'h0, crossover_scheme_select}, 32'h1f);
        $display("test crossover done");

        // Unmapped accesses
        axi_read(9'h068, rd, rsp);
        check("unmapped rdata", rd, 32'h0);
        check("unmapped rresp", {30'h0, rsp}, {30'h0, link_status_pkg::RESP_SLVERR});
        axi_write(9'h000, 32'h0000_00ff, 4'hf, rsp);
        check("unmapped bresp", {30'h0, rsp}, {30'h0, link_status_pkg::RESP_SLVERR});
        $display("test unmapped done");

        // Interrupt: clear, mask, raise, clear again
        axi_write({link_status_pkg::IDX_IRQ_ST, 2'b00}, 32'h1f, 4'h1, rsp);
        axi_read({link_status_pkg::IDX_IRQ_ST, 2'b00}, rd, rsp);
        check("irq cleared", rd, 32'h0);
        axi_write({link_status_pkg::IDX_IRQ_MK, 2'b00}, 32'h04, 4'h1, rsp);
        axi_read({link_status_pkg::IDX_IRQ_MK, 2'b00}, rd, rsp);
        check("mask read", rd, 32'h04);
        @(posedge aclk);
        flags[0][1] <= 1'b1;
        repeat (6) @(posedge aclk);
        axi_read({link_status_pkg::IDX_IRQ_ST, 2'b00}, rd, rsp);
        check("masked event", rd, 32'h02);
        check("irq masked", {31'h0, irq}, 32'h0);
        @(posedge aclk);
        flags[3][2] <= 1'b1;
        repeat (6) @(posedge aclk);
        check("irq raised", {31'h0, irq}, 32'h1);
        axi_write({link_status_pkg::IDX_IRQ_ST, 2'b00}, 32'h04, 4'h1, rsp);
        repeat (2) @(posedge aclk);
        check("irq dropped", {31'h0, irq}, 32'h0);
        axi_read({link_status_pkg::IDX_IRQ_ST, 2'b00}, rd, rsp);
        check("status left", rd, 32'h02);
        $display("test interrupt done");

        results();
    end

endmodule : test_port_link_status_regs
`default_nettype wire
